// ===== design/tpr_trap_unit.sv
/*
  tpr_trap_unit: picks one pending interrupt or trap per cycle and records restart state.
  assumes pipeline supplies pc of the executing (curr) and following (next) instruction,
  and the access channel reports the in-flight or faulting access each cycle.
*/
// Function
// (RL1) capture pc history on exceptions
// (RL2) record faulting access in channel registers
// (RL3) inst traps: mid pc curr or next
// (RL4) async events: mid pc is next
// (RL5) execution traps: old pc trapping, mid next
// (RL6) execution traps load exception opcode
// (RL7) fetch faults trap only on execute
// (RL8) nonsequential fetch discards prefetch fault
// (RL9) fixed fourteen level priority order
// (RL10) level 2 next, channel always valid
// (RL11) level 3 next, channel valid some
// (RL12) level 13 curr, channel not applicable
// (RL13) fatal warning loads channel only mid-access
// (RL14) execution traps report next as restart
// (RL15) losers stay pending or regenerate
// (RL16) async levels may save multiple state
// (RL17) sources hold requests until taken
`timescale 1ns/1ns
`default_nettype none
module tpr_trap_unit (
  input  wire logic                          i_clk,
  input  wire logic                          i_resetn,
  input  wire logic                          i_fatal_warning,
  input  wire logic                          i_dtrans_fault,
  input  wire logic                          i_exec_fault,
  input  wire logic                          i_exec_fault_chan,
  input  wire logic                          i_dacc_error,
  input  wire logic [1:0]                    i_external_trap,
  input  wire logic [3:0]                    i_external_interrupt_request,
  input  wire logic                          i_timer_pending,
  input  wire logic                          i_trace_pending,
  input  wire logic                          i_ifetch_fault,
  input  wire logic                          i_illegal_op,
  input  wire logic                          i_exec_valid,
  input  wire logic                          i_nonseq_fetch,
  input  wire logic [tpr_pkg::ADDR_W-1:0]    i_pc_curr,
  input  wire logic [tpr_pkg::ADDR_W-1:0]    i_pc_next,
  input  wire logic [tpr_pkg::OPC_W-1:0]     i_opcode,
  input  wire logic                          i_access_busy,
  input  wire logic                          i_multiple_active,
  input  wire logic [tpr_pkg::ADDR_W-1:0]    i_ch_addr,
  input  wire logic [tpr_pkg::DATA_W-1:0]    i_ch_data,
  input  wire logic [tpr_pkg::CTRL_W-1:0]    i_ch_ctrl,
  output logic                               o_take,
  output logic [tpr_pkg::CAUSE_W-1:0]        o_cause,
  output logic [tpr_pkg::ADDR_W-1:0]         o_restart_pc_history_new,
  output logic [tpr_pkg::ADDR_W-1:0]         o_restart_pc_history_mid,
  output logic [tpr_pkg::ADDR_W-1:0]         o_restart_pc_history_old,
  output logic [tpr_pkg::OPC_W-1:0]          o_exc_opcode,
  output logic [tpr_pkg::ADDR_W-1:0]         o_ch_addr,
  output logic [tpr_pkg::DATA_W-1:0]         o_ch_data,
  output logic [tpr_pkg::CTRL_W-1:0]         o_ch_ctrl,
  output logic                               o_ch_valid
);
  import tpr_pkg::*;

  logic       fetch_fault_held;
  logic       ifetch_live;
  logic [NUM_LEVELS:1] req;
  tpr_cause_t next_cause;
  logic       next_take;
  logic       inst_class;
  logic       load_chan;

  // prefetch fault is held until its instruction executes or flow is redirected
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      fetch_fault_held <= 1'b0;
    end else if (i_nonseq_fetch) begin
      fetch_fault_held <= 1'b0;                           // [RL8]
    end else if (next_take && next_cause == TPR_IFETCH) begin
      fetch_fault_held <= 1'b0;
    end else if (i_ifetch_fault) begin
      fetch_fault_held <= 1'b1;
    end
  end

  // only raised when the faulting instruction is attempted
  assign ifetch_live = (fetch_fault_held | i_ifetch_fault) & i_exec_valid & ~i_nonseq_fetch; // [RL7] [RL8]

  // request vector indexed by priority level; levels 13/14 regenerate on re-execution
  always_comb begin
    req      = '0;
    req[1]   = i_fatal_warning;
    req[2]   = i_dtrans_fault;
    req[3]   = i_exec_fault;
    req[4]   = i_dacc_error;
    req[5]   = i_external_trap[0];
    req[6]   = i_external_trap[1];
    req[7]   = i_external_interrupt_request[0];
    req[8]   = i_external_interrupt_request[1];
    req[9]   = i_external_interrupt_request[2];
    req[10]  = i_external_interrupt_request[3];
    req[11]  = i_timer_pending;
    req[12]  = i_trace_pending;
    req[13]  = ifetch_live;
    req[14]  = i_illegal_op & i_exec_valid;
  end

  // lowest level number wins; losers are not consumed here
  always_comb begin
    next_cause = TPR_NONE;
    next_take  = 1'b0;
    for (int lvl = NUM_LEVELS; lvl >= 1; lvl--) begin   // [RL9] [RL15]
      if (req[lvl]) begin
        next_cause = tpr_cause_t'(lvl[CAUSE_W-1:0]);
        next_take  = 1'b1;
      end
    end
  end

  // curr-class restart only for fetch and illegal levels
  assign inst_class = (next_cause == TPR_IFETCH) || (next_cause == TPR_ILLEGAL);

  always_comb begin
    case (next_cause)
      TPR_WARN:    load_chan = i_access_busy;                     // [RL13]
      TPR_DTRANS:  load_chan = 1'b1;                              // [RL10]
      TPR_IEXEC:   load_chan = i_exec_fault_chan;                 // [RL11]
      TPR_DACC:    load_chan = 1'b1;                              // [RL2]
      TPR_TRAP0, TPR_TRAP1, TPR_INT0, TPR_INT1, TPR_INT2, TPR_INT3,
      TPR_TIMER, TPR_TRACE:
                   load_chan = i_multiple_active;                 // [RL16]
      TPR_IFETCH, TPR_ILLEGAL:
                   load_chan = 1'b0;                              // [RL12]
      default:     load_chan = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_take  <= 1'b0;
      o_cause <= TPR_NONE;
    end else begin
      o_take  <= next_take;
      o_cause <= next_cause;
    end
  end

  // pc history: mid holds the restart point, old the trapping instruction
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_restart_pc_history_new <= PC_RESET;
      o_restart_pc_history_mid <= PC_RESET;
      o_restart_pc_history_old <= PC_RESET;
    end else if (next_take) begin                                  // [RL1]
      o_restart_pc_history_new <= i_pc_next;
      if (inst_class) begin
        o_restart_pc_history_mid <= i_pc_curr;                     // [RL3] [RL12]
      end else begin
        o_restart_pc_history_mid <= i_pc_next;                     // [RL4] [RL10] [RL11] [RL14]
      end
      o_restart_pc_history_old <= i_pc_curr;                       // [RL5]
    end
  end

  // opcode captured only for execution traps
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_exc_opcode <= OPC_RESET;
    end else if (next_take && next_cause == TPR_IEXEC) begin
      o_exc_opcode <= i_opcode;                                    // [RL6]
    end
  end

  // channel contents are kept when not applicable so software state survives
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_ch_addr  <= PC_RESET;
      o_ch_data  <= CH_RESET;
      o_ch_ctrl  <= CH_RESET;
      o_ch_valid <= 1'b0;
    end else if (next_take) begin
      o_ch_valid <= load_chan;
      if (load_chan) begin
        o_ch_addr <= i_ch_addr;                                    // [RL2]
        o_ch_data <= i_ch_data;
        o_ch_ctrl <= i_ch_ctrl;
      end
    end
  end
endmodule // tpr_trap_unit
`default_nettype wire

// ===== common/tpr_pkg.sv
/*
  tpr_pkg: constants for the trap priority and restart reporting unit.
  assumes one processor clock; widths of addresses and opcodes are 32 and 8 bits.
*/
package tpr_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CTRL_W = 32;
  localparam int OPC_W  = 8;
  localparam int NUM_LEVELS = 14;
  localparam int CAUSE_W = 4;

  // cause codes equal the priority level, 0 means nothing taken
  typedef enum logic [3:0] {
    TPR_NONE    = 4'h0,
    TPR_WARN    = 4'h1,
    TPR_DTRANS  = 4'h2,
    TPR_IEXEC   = 4'h3,
    TPR_DACC    = 4'h4,
    TPR_TRAP0   = 4'h5,
    TPR_TRAP1   = 4'h6,
    TPR_INT0    = 4'h7,
    TPR_INT1    = 4'h8,
    TPR_INT2    = 4'h9,
    TPR_INT3    = 4'ha,
    TPR_TIMER   = 4'hb,
    TPR_TRACE   = 4'hc,
    TPR_IFETCH  = 4'hd,
    TPR_ILLEGAL = 4'he
  } tpr_cause_t;

  localparam logic [ADDR_W-1:0] PC_RESET   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CH_RESET   = 32'h0000_0000;
  localparam logic [OPC_W-1:0]  OPC_RESET  = 8'h00;
endpackage

// ===== verif/tpr_chk.sv
/* tpr_chk: port assertions on the trap unit; assumes the bind below and one clock */
`timescale 1ns/1ns
`default_nettype none
module tpr_chk (
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic        i_fatal_warning,
  input wire logic        i_access_busy,
  input wire logic        o_take,
  input wire logic        o_ch_valid,
  input wire logic [3:0]  o_cause,
  input wire logic [31:0] i_pc_curr,
  input wire logic [31:0] i_pc_next,
  input wire logic [31:0] o_restart_pc_history_mid,
  input wire logic [31:0] o_restart_pc_history_old
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  warn_wins_a: assert property (i_fatal_warning |=> o_take && o_cause == 4'h1) else $error("warn lost");
  take_code_a: assert property (o_take == (o_cause != 4'h0)) else $error("bad cause");
  mid_next_a: assert property (o_take && o_cause < 4'hd |-> o_restart_pc_history_mid == $past(i_pc_next))
    else $error("mid not next");
  mid_curr_a: assert property (o_take && o_cause > 4'hc |-> o_restart_pc_history_mid == $past(i_pc_curr))
    else $error("mid not curr");
  old_pc_a: assert property (o_take |-> o_restart_pc_history_old == $past(i_pc_curr)) else $error("old pc");
  warn_chan_a: assert property (o_take && o_cause == 4'h1 |-> o_ch_valid == $past(i_access_busy))
    else $error("warn chan");
  dtr_chan_a: assert property (o_take && o_cause == 4'h2 |-> o_ch_valid) else $error("dtr chan");
  fetch_chan_a: assert property (o_take && o_cause > 4'hc |-> !o_ch_valid) else $error("fetch chan");
  cover property (o_take && o_cause == 4'h1 && o_ch_valid);
  cover property (o_take && o_cause == 4'h7);
  cover property (o_take && o_cause == 4'hd);
endmodule // tpr_chk
bind tpr_trap_unit tpr_chk u_chk (
  .i_clk                    (i_clk),
  .i_resetn                 (i_resetn),
  .i_fatal_warning          (i_fatal_warning),
  .i_access_busy            (i_access_busy),
  .o_take                   (o_take),
  .o_ch_valid               (o_ch_valid),
  .o_cause                  (o_cause),
  .i_pc_curr                (i_pc_curr),
  .i_pc_next                (i_pc_next),
  .o_restart_pc_history_mid (o_restart_pc_history_mid),
  .o_restart_pc_history_old (o_restart_pc_history_old)
);
`default_nettype wire

// ===== verif/tpr_src.sv
/* tpr_src: external trap and interrupt sources; assumes take pulses of the trap unit */
`timescale 1ns/1ns
`default_nettype none
module tpr_src (
  input  wire logic       i_clk, i_take,
  input  wire logic [3:0] i_cause,
  input  wire logic [5:0] i_raise,
  output logic [5:0]      o_req
);
  initial o_req = 6'h00;
  // unit keeps no copy of these levels, so each is held until its own take
  always @(negedge i_clk) o_req <= (o_req | i_raise) & ~(i_take ? 6'h01 << (i_cause - 4'h5) : 6'h00);
endmodule // tpr_src
`default_nettype wire

// ===== verif/trap_priority_and_restart_reporting_bench.sv
/* bench: priority and restart scenarios; assumes tpr_src drives the external levels */
`timescale 1ns/1ns
`default_nettype none
module trap_priority_and_restart_reporting_bench;
  logic        i_clk, i_resetn, i_fatal_warning, i_dtrans_fault, i_exec_fault, i_exec_fault_chan, i_dacc_error;
  logic        i_timer_pending, i_trace_pending, i_ifetch_fault, i_illegal_op, i_exec_valid, i_nonseq_fetch;
  logic        i_access_busy, i_multiple_active, o_take, o_ch_valid;
  logic [1:0]  i_external_trap;
  logic [3:0]  i_external_interrupt_request, o_cause;
  logic [5:0]  raise;
  logic [7:0]  i_opcode, o_exc_opcode;
  logic [31:0] i_pc_curr, i_pc_next, i_ch_addr, i_ch_data, i_ch_ctrl, o_ch_addr, o_ch_data, o_ch_ctrl;
  logic [31:0] o_restart_pc_history_new, o_restart_pc_history_mid, o_restart_pc_history_old;
  logic [31:0] exp_addr, exp_data, exp_ctrl;
  int          err_total, checked;
  tpr_trap_unit uut (.*);
  tpr_src src (.i_clk, .i_take(o_take), .i_cause(o_cause), .i_raise(raise),
    .o_req({i_external_interrupt_request, i_external_trap}));
  initial forever #2 i_clk = ~i_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // pc inputs stay put across a take, so they are the expected history
  // fresh pc and channel values per take, so stale history cannot pass; v is the rule's channel verdict
  task automatic fire(input logic [3:0] c, input logic v);
    i_pc_curr = i_pc_curr + 32'h0000_0010;
    i_pc_next = i_pc_curr + 32'h0000_0004;
    i_ch_addr = i_ch_addr + 32'h0000_0100;
    i_ch_data = ~i_ch_addr;
    i_ch_ctrl = {28'h000_0000, c};
    if (v) begin
      {exp_addr, exp_data, exp_ctrl} = {i_ch_addr, i_ch_data, i_ch_ctrl};
    end
    @(negedge i_clk);
    chk(o_take, 1'b1);
    chk(o_cause, c);
    chk(o_restart_pc_history_mid, c > 4'hc ? i_pc_curr : i_pc_next);
    chk(o_restart_pc_history_old, i_pc_curr);
    chk(o_restart_pc_history_new, i_pc_next);
    chk(o_ch_valid, v);
    chk(o_ch_addr, exp_addr);
    chk(o_ch_data, exp_data);
    chk(o_ch_ctrl, exp_ctrl);
  endtask
  task automatic complete_run(input int extra);
    err_total += extra;
    $display("mismatches %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_async;
    {i_fatal_warning, i_dtrans_fault, i_exec_fault, i_timer_pending} = 4'hf;
    raise <= 6'h3f;
    fire(4'h1, 1'b1);
    i_fatal_warning = 1'b0;
    raise <= 6'h00;
    fire(4'h2, 1'b1);
    {i_dtrans_fault, i_exec_fault_chan} = 2'b00;
    fire(4'h3, 1'b0);
    chk(o_exc_opcode, 8'h5a);
    // new opcode: later non-execution takes must not capture it
    {i_exec_fault, i_dacc_error, i_opcode} = {2'b01, 8'ha5};
    fire(4'h4, 1'b1);
    i_dacc_error = 1'b0;
    for (int k = 5; k < 12; k++) begin
      i_multiple_active = k[0];
      fire(4'(k), k[0]);
    end
    {i_timer_pending, i_access_busy, i_fatal_warning} = 3'b001;
    fire(4'h1, 1'b0);
    i_fatal_warning = 1'b0;
    chk(o_exc_opcode, 8'h5a);
  endtask
  // mid-run reset with a request held through it
  task automatic t_reset;
    {i_resetn, i_fatal_warning, i_access_busy} = 3'b011;
    @(negedge i_clk);
    chk(o_take, 1'b0);
    chk(o_cause, 4'h0);
    chk(o_restart_pc_history_mid, 32'h0000_0000);
    chk(o_ch_valid, 1'b0);
    chk(o_ch_addr, 32'h0000_0000);
    chk(o_exc_opcode, 8'h00);
    {exp_addr, exp_data, exp_ctrl} = '0;
    i_resetn = 1'b1;
    fire(4'h1, 1'b1);
    i_fatal_warning = 1'b0;
  endtask
  task automatic t_fetch;
    i_ifetch_fault = 1'b1;
    @(negedge i_clk);
    chk(o_take, 1'b0);
    {i_ifetch_fault, i_nonseq_fetch} = 2'h1;
    @(negedge i_clk);
    {i_nonseq_fetch, i_exec_valid} = 2'h1;
    @(negedge i_clk);
    chk(o_take, 1'b0);
    i_ifetch_fault = 1'b1;
    fire(4'hd, 1'b0);
    {i_ifetch_fault, i_illegal_op} = 2'h1;
    fire(4'he, 1'b0);
  endtask
  initial begin
    {i_clk, i_resetn, i_fatal_warning, i_dtrans_fault, i_exec_fault, i_dacc_error, i_timer_pending} = '0;
    {i_trace_pending, i_ifetch_fault, i_illegal_op, i_exec_valid, i_nonseq_fetch, raise, err_total, checked} = '0;
    {i_ch_data, i_ch_ctrl, i_access_busy, i_multiple_active, i_exec_fault_chan, i_opcode} = {64'h0, 11'h75a};
    {i_pc_curr, i_pc_next, i_ch_addr} = {32'h0000_0100, 32'h0000_0104, 32'h0000_1234};
    {exp_addr, exp_data, exp_ctrl} = '0;
    repeat (2) @(negedge i_clk);
    i_resetn = 1'b1;
    @(negedge i_clk);
    t_async;
    t_reset;
    t_fetch;
    complete_run(0);
  end
  initial #2000 complete_run(1);
endmodule // trap_priority_and_restart_reporting_bench
`default_nettype wire
